// ---- design/plmcr_consts.svh ----
// Offsets, field positions and reset values of the PHY LED and crossover control registers
`ifndef PLMCR_CONSTS_SVH
`define PLMCR_CONSTS_SVH

// Register indices; byte address is four times the index
`define PLMCR_IDX_ELAST 8'h17
`define PLMCR_IDX_LED 8'h18
`define PLMCR_IDX_PHY 8'h19
`define PLMCR_ADDR_ELAST (`PLMCR_IDX_ELAST << 2)
`define PLMCR_ADDR_LED (`PLMCR_IDX_LED << 2)
`define PLMCR_ADDR_PHY (`PLMCR_IDX_PHY << 2)

// Field positions
`define PLMCR_ELAST_LSB 0
`define PLMCR_ELAST_MSB 1
`define PLMCR_LED_OVR_BIT 4
`define PLMCR_LED_VAL_BIT 1
`define PLMCR_XO_EN_BIT 15
`define PLMCR_FORCE_XO_BIT 14
`define PLMCR_PAUSE_RX_BIT 13
`define PLMCR_PAUSE_TX_BIT 12
`define PLMCR_INJ_ERR_BIT 11

// Reset values
`define PLMCR_ELAST_RST 2'b01
`define PLMCR_LED_OVR_RST 1'b0
`define PLMCR_LED_VAL_RST 1'b0
`define PLMCR_FORCE_XO_RST 1'b0

// Bus responses
`define PLMCR_RESP_OKAY 2'b00
`define PLMCR_RESP_DECERR 2'b11

`endif

// ---- design/plmcr_pkg.sv ----
// Types shared by the PHY LED and crossover control register block
package plmcr_pkg;

   // Elasticity tolerance codes
   typedef enum logic [1:0] {
      PLMCR_TOL_14 = 2'b00,
      PLMCR_TOL_2  = 2'b01,
      PLMCR_TOL_6  = 2'b10,
      PLMCR_TOL_10 = 2'b11
   } plmcr_tol_e;

   // Register select from address decode
   typedef enum logic [1:0] {
      PLMCR_SEL_NONE  = 2'b00,
      PLMCR_SEL_ELAST = 2'b01,
      PLMCR_SEL_LED   = 2'b10,
      PLMCR_SEL_PHY   = 2'b11
   } plmcr_sel_e;

   // Pause advertisement pair, bits 11:10 of an ability word
   typedef struct packed {
      logic asm_dir;
      logic pause;
   } plmcr_pause_s;

endpackage : plmcr_pkg

// ---- design/plmcr_regs.sv ----
// PHY LED override, crossover and pause control registers behind AXI4-Lite
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "plmcr_consts.svh"

module plmcr_regs #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      srst,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output      logic                      s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output      logic                      s_axi_wready,
   // AXI4-Lite write response
   output      logic [1:0]                s_axi_bresp,
   output      logic                      s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0]         s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output      logic                      s_axi_arready,
   // AXI4-Lite read data
   output      logic [31:0]               s_axi_rdata,
   output      logic [1:0]                s_axi_rresp,
   output      logic                      s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // Straps and PHY status
   input  wire logic                      strap_auto_crossover,
   input  wire logic                      link_status_in,
   input  wire logic                      an_enable_in,
   input  wire logic                      crossover_detect_in,
   input  wire logic                      an_full_duplex_in,
   input  wire plmcr_pkg::plmcr_pause_s   local_advertisement,
   input  wire plmcr_pkg::plmcr_pause_s   partner_ability,
   // PHY controls
   output      logic                      link_indicator_out,
   output      logic                      tp_receive_on_transmit_pair,
   output      logic                      auto_crossover_active,
   output      logic [1:0]                rx_elastic_tolerance,
   output      logic [3:0]                rx_elastic_slack_bits,
   output      logic                      selftest_inject_error,
   output      logic                      pause_rx_enable,
   output      logic                      pause_tx_enable
);

   // Elaboration check on address width
   if (ADDR_W < 8) begin : g_chk
      $error("plmcr_regs needs ADDR_W of at least 8");
   end

   // Address decode, shared by read and write paths
   function automatic plmcr_pkg::plmcr_sel_e reg_sel(input logic [ADDR_W-1:0] a);
      // Whole-address compare, so upper bits must be zero at any width
      if (a == ADDR_W'(`PLMCR_ADDR_ELAST)) begin
         return plmcr_pkg::PLMCR_SEL_ELAST;
      end
      if (a == ADDR_W'(`PLMCR_ADDR_LED)) begin
         return plmcr_pkg::PLMCR_SEL_LED;
      end
      if (a == ADDR_W'(`PLMCR_ADDR_PHY)) begin
         return plmcr_pkg::PLMCR_SEL_PHY;
      end
      return plmcr_pkg::PLMCR_SEL_NONE;
   endfunction : reg_sel

   // Tolerance in bits per code
   function automatic logic [3:0] tol_bits(input logic [1:0] code);
      unique case (plmcr_pkg::plmcr_tol_e'(code))
         plmcr_pkg::PLMCR_TOL_14: return 4'he;
         plmcr_pkg::PLMCR_TOL_2:  return 4'h2;
         plmcr_pkg::PLMCR_TOL_6:  return 4'h6;
         plmcr_pkg::PLMCR_TOL_10: return 4'ha;
      endcase
   endfunction : tol_bits

   logic [1:0]        elast_reg;
   logic              led_ovr_reg;
   logic              led_val_reg;
   logic              xo_en_reg;
   logic              force_xo_reg;
   logic              inj_err_reg;
   logic              pause_rx_reg;
   logic              pause_tx_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0]       wdata_reg;
   logic [3:0]        wstrb_reg;
   logic              awready_reg;
   logic              wready_reg;
   logic              bvalid_reg;
   logic [1:0]        bresp_reg;
   logic              arready_reg;
   logic              rvalid_reg;
   logic [31:0]       rdata_reg;
   logic [1:0]        rresp_reg;
   logic              link_out_reg;
   logic              tp_cross_reg;
   logic              auto_act_reg;
   logic [3:0]        slack_reg;
   logic              wr_fire;
   logic              lo_en;
   logic              hi_en;
   plmcr_pkg::plmcr_sel_e wr_sel;
   logic [31:0]       rd_next;

   // Write fires once both address and data are held and no response pends
   assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
   assign wr_sel  = reg_sel(awaddr_reg);
   assign lo_en   = wr_fire && wstrb_reg[0];
   assign hi_en   = wr_fire && wstrb_reg[1];

   // Write address channel; ready drops while an address is held
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         awready_reg <= 1'b1;
         awaddr_reg  <= '0;
      end else if (s_axi_awvalid && awready_reg) begin
         awready_reg <= 1'b0;
         awaddr_reg  <= s_axi_awaddr;
      end else if (bvalid_reg && s_axi_bready) begin
         awready_reg <= 1'b1;
      end
   end

   // Write data channel, taken independently of the address
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wready_reg <= 1'b1;
         wdata_reg  <= '0;
         wstrb_reg  <= '0;
      end else if (s_axi_wvalid && wready_reg) begin
         wready_reg <= 1'b0;
         wdata_reg  <= s_axi_wdata;
         wstrb_reg  <= s_axi_wstrb;
      end else if (bvalid_reg && s_axi_bready) begin
         wready_reg <= 1'b1;
      end
   end

   // Write response; unmapped addresses answer DECERR
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= `PLMCR_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= (wr_sel == plmcr_pkg::PLMCR_SEL_NONE) ? `PLMCR_RESP_DECERR
                                                             : `PLMCR_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         elast_reg <= `PLMCR_ELAST_RST;
      end else if (lo_en && wr_sel == plmcr_pkg::PLMCR_SEL_ELAST) begin
         elast_reg <= wdata_reg[`PLMCR_ELAST_MSB:`PLMCR_ELAST_LSB];
      end
   end

   // only bits 4 and 1 are stored, upper byte ignored
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         led_ovr_reg <= `PLMCR_LED_OVR_RST;
         led_val_reg <= `PLMCR_LED_VAL_RST;
      end else if (lo_en && wr_sel == plmcr_pkg::PLMCR_SEL_LED) begin
         led_ovr_reg <= wdata_reg[`PLMCR_LED_OVR_BIT];
         led_val_reg <= wdata_reg[`PLMCR_LED_VAL_BIT];
      end
   end

   // strap caught at reset, software may overwrite later
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         xo_en_reg <= strap_auto_crossover;
      end else if (hi_en && wr_sel == plmcr_pkg::PLMCR_SEL_PHY) begin
         xo_en_reg <= wdata_reg[`PLMCR_XO_EN_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         force_xo_reg <= `PLMCR_FORCE_XO_RST;
      end else if (hi_en && wr_sel == plmcr_pkg::PLMCR_SEL_PHY) begin
         force_xo_reg <= wdata_reg[`PLMCR_FORCE_XO_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         inj_err_reg <= 1'b0;
      end else begin
         inj_err_reg <= hi_en && wr_sel == plmcr_pkg::PLMCR_SEL_PHY
                        && wdata_reg[`PLMCR_INJ_ERR_BIT];
      end
   end

   // pause resolution, gated by full-duplex outcome
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pause_rx_reg <= 1'b0;
         pause_tx_reg <= 1'b0;
      end else begin
         pause_tx_reg <= an_full_duplex_in && partner_ability.pause
                         && (local_advertisement.pause
                             || (local_advertisement.asm_dir && partner_ability.asm_dir));
         pause_rx_reg <= an_full_duplex_in && local_advertisement.pause
                         && (partner_ability.pause
                             || (local_advertisement.asm_dir && partner_ability.asm_dir));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         link_out_reg <= 1'b0;
      end else begin
         link_out_reg <= led_ovr_reg ? led_val_reg : link_status_in;
      end
   end

   // pair selection; force wins over automatic detection
   // automatic crossover held off without auto-negotiation
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         auto_act_reg <= 1'b0;
         tp_cross_reg <= 1'b0;
      end else begin
         auto_act_reg <= xo_en_reg && an_enable_in;
         tp_cross_reg <= force_xo_reg || (xo_en_reg && an_enable_in && crossover_detect_in);
      end
   end

   // slack size handed to the receive elasticity buffer
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         slack_reg <= 4'h0;
      end else begin
         slack_reg <= tol_bits(elast_reg);
      end
   end

   // read mux returns stored settings and resolved pause status; reserved bits zero
   always_comb begin
      rd_next = 32'h0000_0000;
      unique case (reg_sel(s_axi_araddr))
         plmcr_pkg::PLMCR_SEL_ELAST: begin
            rd_next[`PLMCR_ELAST_MSB:`PLMCR_ELAST_LSB] = elast_reg;
         end
         plmcr_pkg::PLMCR_SEL_LED: begin
            rd_next[`PLMCR_LED_OVR_BIT] = led_ovr_reg;
            rd_next[`PLMCR_LED_VAL_BIT] = led_val_reg;
         end
         plmcr_pkg::PLMCR_SEL_PHY: begin
            rd_next[`PLMCR_XO_EN_BIT]    = xo_en_reg;
            rd_next[`PLMCR_FORCE_XO_BIT] = force_xo_reg;
            rd_next[`PLMCR_PAUSE_RX_BIT] = pause_rx_reg;
            rd_next[`PLMCR_PAUSE_TX_BIT] = pause_tx_reg;
            rd_next[`PLMCR_INJ_ERR_BIT]  = inj_err_reg;
         end
         plmcr_pkg::PLMCR_SEL_NONE: begin
            rd_next = 32'h0000_0000;
         end
      endcase
   end

   // Read channel; one read in flight
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= `PLMCR_RESP_OKAY;
      end else if (s_axi_arvalid && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= rd_next;
         rresp_reg   <= (reg_sel(s_axi_araddr) == plmcr_pkg::PLMCR_SEL_NONE)
                        ? `PLMCR_RESP_DECERR : `PLMCR_RESP_OKAY;
      end else if (rvalid_reg && s_axi_rready) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
      end
   end

   // Outputs straight from flip-flops
   assign s_axi_awready               = awready_reg;
   assign s_axi_wready                = wready_reg;
   assign s_axi_bvalid                = bvalid_reg;
   assign s_axi_bresp                 = bresp_reg;
   assign s_axi_arready               = arready_reg;
   assign s_axi_rvalid                = rvalid_reg;
   assign s_axi_rdata                 = rdata_reg;
   assign s_axi_rresp                 = rresp_reg;
   assign link_indicator_out          = link_out_reg;
   assign tp_receive_on_transmit_pair = tp_cross_reg;
   assign auto_crossover_active       = auto_act_reg;
   assign rx_elastic_tolerance        = elast_reg;
   assign rx_elastic_slack_bits       = slack_reg;
   assign selftest_inject_error       = inj_err_reg;
   assign pause_rx_enable             = pause_rx_reg;
   assign pause_tx_enable             = pause_tx_reg;

   // Helper: which register the pending read targets
   plmcr_pkg::plmcr_sel_e rd_sel_reg;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_sel_reg <= plmcr_pkg::PLMCR_SEL_NONE;
      end else if (s_axi_arvalid && arready_reg) begin
         rd_sel_reg <= reg_sel(s_axi_araddr);
      end
   end

   // Checks on reset values and register effects
   property p_elast_rst;
      @(posedge sys_clk) srst |=> elast_reg == 2'b01;
   endproperty
   a_elast_rst: assert property (p_elast_rst) else $error("elasticity reset not 01");

   property p_slack;
      @(posedge sys_clk) disable iff (srst)
         (elast_reg == 2'b00) [*2] |-> slack_reg == 4'he;
   endproperty
   a_slack: assert property (p_slack) else $error("slack not 14 for code 00");

   property p_led;
      @(posedge sys_clk) disable iff (srst)
         led_ovr_reg |=> link_indicator_out == $past(led_val_reg);
   endproperty
   a_led: assert property (p_led) else $error("LED override not applied");

   property p_led_norm;
      @(posedge sys_clk) disable iff (srst)
         !led_ovr_reg |=> link_indicator_out == $past(link_status_in);
   endproperty
   a_led_norm: assert property (p_led_norm) else $error("LED not following link");

   property p_led_read;
      @(posedge sys_clk) disable iff (srst)
         s_axi_arvalid && arready_reg && reg_sel(s_axi_araddr) == plmcr_pkg::PLMCR_SEL_LED
         |=> s_axi_rdata[4] == $past(led_ovr_reg) && s_axi_rdata[1] == $past(led_val_reg);
   endproperty
   a_led_read: assert property (p_led_read) else $error("LED read not stored value");

   property p_led_rsvd;
      @(posedge sys_clk) disable iff (srst)
         s_axi_rvalid && rd_sel_reg == plmcr_pkg::PLMCR_SEL_LED
         |-> s_axi_rdata[31:5] == '0 && s_axi_rdata[3:2] == 2'b00 && !s_axi_rdata[0];
   endproperty
   a_led_rsvd: assert property (p_led_rsvd) else $error("LED reserved bits nonzero");

   property p_strap;
      @(posedge sys_clk) srst |=> xo_en_reg == $past(strap_auto_crossover);
   endproperty
   a_strap: assert property (p_strap) else $error("strap not captured");

   property p_force;
      @(posedge sys_clk) disable iff (srst)
         force_xo_reg |=> tp_receive_on_transmit_pair;
   endproperty
   a_force: assert property (p_force) else $error("forced crossover not applied");

   property p_half_duplex;
      @(posedge sys_clk) disable iff (srst)
         !an_full_duplex_in |=> !pause_rx_enable && !pause_tx_enable;
   endproperty
   a_half_duplex: assert property (p_half_duplex) else $error("pause without full duplex");

   property p_pause_tx;
      @(posedge sys_clk) disable iff (srst)
         an_full_duplex_in && local_advertisement.pause && partner_ability.pause
         |=> pause_tx_enable && pause_rx_enable;
   endproperty
   a_pause_tx: assert property (p_pause_tx) else $error("symmetric pause not set");

   property p_inject;
      @(posedge sys_clk) disable iff (srst)
         inj_err_reg |=> !inj_err_reg;
   endproperty
   a_inject: assert property (p_inject) else $error("inject error not self clearing");

   c_write_phy: cover property (@(posedge sys_clk) wr_fire && wr_sel == plmcr_pkg::PLMCR_SEL_PHY);
   c_read_led: cover property (@(posedge sys_clk) s_axi_rvalid && rd_sel_reg == plmcr_pkg::PLMCR_SEL_LED);
   c_inject: cover property (@(posedge sys_clk) selftest_inject_error);

endmodule : plmcr_regs

// ---- testbench/plmcr_mac_peer.sv ----
// Far-side model: MAC and station software setting the PHY status lines
`timescale 1ns/10ps

module plmcr_mac_peer (
   // Clock
   input  wire logic                    sys_clk,
   // Bench commands and current tolerance
   input  wire logic [7:0]              cmd,
   input  wire logic [1:0]              tol,
   // PHY status lines
   output      logic                    link_status_in,
   output      logic                    an_enable_in,
   output      logic                    crossover_detect_in,
   output      logic                    an_full_duplex_in,
   output      plmcr_pkg::plmcr_pause_s local_advertisement,
   output      plmcr_pkg::plmcr_pause_s partner_ability,
   // Frame cap the MAC keeps
   output      logic [15:0]             max_frame_bytes
);

   // Status moves only just after an edge, never on it
   always @(posedge sys_clk) begin
      {link_status_in, an_enable_in, crossover_detect_in, an_full_duplex_in,
       local_advertisement, partner_ability} <= cmd;
   end

   // halve frame length
   // Worst case 100 ppm spread, so frames are held to half the supported size
   always_comb begin
      case (tol)
         2'b00: max_frame_bytes = 16'h20d0;
         2'b01: max_frame_bytes = 16'h04b0;
         2'b10: max_frame_bytes = 16'h0e10;
         default: max_frame_bytes = 16'h1770;
      endcase
   end

endmodule : plmcr_mac_peer

// ---- testbench/plmcr_regs_bench.sv ----
// Self-checking bench for the LED override and crossover control registers
`timescale 1ns/10ps
`include "plmcr_consts.svh"

module plmcr_regs_bench;
   logic                    sys_clk, srst, strap;
   logic [7:0]              awaddr, araddr, cmd;
   logic [31:0]             wdata, rdata, rd;
   logic [3:0]              wstrb, slack;
   logic                    awvalid, awready, wvalid, wready, bvalid, bready;
   logic                    arvalid, arready, rvalid, rready;
   logic [1:0]              bresp, rresp, resp, tol;
   logic                    link, an, det, fd, led, xpair, xauto, inj, prx, ptx;
   logic                    erx, etx;
   logic [15:0]             mfb;
   plmcr_pkg::plmcr_pause_s lad, lpa;
   int                      n_mismatch, compares, n_inj;
   logic [3:0]              slack_tab [4] = '{4'he, 4'h2, 4'h6, 4'ha};
   logic [15:0]             mfb_tab [4] = '{16'h20d0, 16'h04b0, 16'h0e10, 16'h1770};

   // Clock, 25 ns period
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   plmcr_regs #(.ADDR_W(8)) plmcr_regs_i (
      .sys_clk(sys_clk), .srst(srst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .strap_auto_crossover(strap), .link_status_in(link), .an_enable_in(an),
      .crossover_detect_in(det), .an_full_duplex_in(fd),
      .local_advertisement(lad), .partner_ability(lpa),
      .link_indicator_out(led), .tp_receive_on_transmit_pair(xpair),
      .auto_crossover_active(xauto), .rx_elastic_tolerance(tol),
      .rx_elastic_slack_bits(slack), .selftest_inject_error(inj),
      .pause_rx_enable(prx), .pause_tx_enable(ptx));

   plmcr_mac_peer plmcr_mac_peer_i (
      .sys_clk(sys_clk), .cmd(cmd), .tol(tol), .link_status_in(link),
      .an_enable_in(an), .crossover_detect_in(det), .an_full_duplex_in(fd),
      .local_advertisement(lad), .partner_ability(lpa), .max_frame_bytes(mfb));

   // Count inject pulses, one per write of one expected
   always @(posedge sys_clk) begin
      if (inj === 1'b1) n_inj++;
   end

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task close_out;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out

   task hang(input string what);
      n_mismatch++;
      $display("mismatch %s expected answer seen none", what);
      close_out;
   endtask : hang

   // Write: both channels offered together, each dropped when taken
   task wr(input logic [7:0] a, input logic [15:0] d);
      int i;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {16'h0000, d};
      wstrb <= 4'h3;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      resp = bresp;
      bready <= 1'b0;
      if (i == 40) hang("write response");
      @(posedge sys_clk);
   endtask : wr

   task rd_reg(input logic [7:0] a);
      int i;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (i == 40) hang("read data");
      @(posedge sys_clk);
   endtask : rd_reg

   task rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
      rd_reg(a);
      chk(nm, exp, rd);
      chk("rresp", `PLMCR_RESP_OKAY, resp);
   endtask : rchk

   // Watchdog against a stuck run
   initial begin
      repeat (20000) @(posedge sys_clk);
      hang("run length");
   end

   // Main sequence
   initial begin
      {srst, strap} = 2'b11;
      {awaddr, araddr, cmd, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      n_mismatch = 0;
      compares = 0;
      n_inj = 0;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("tolerance", 32'h1, tol);
      chk("slack", 32'h2, slack);
      rchk(`PLMCR_ADDR_ELAST, 32'h1, "elast reg");
      rchk(`PLMCR_ADDR_LED, 32'h0, "led reg");
      rchk(`PLMCR_ADDR_PHY, 32'h8000, "phy reg");
      // Every tolerance code and its slack
      for (int c = 0; c < 4; c++) begin
         wr(`PLMCR_ADDR_ELAST, 16'(c));
         repeat (2) @(posedge sys_clk);
         chk("slack", slack_tab[c], slack);
         chk("frame cap", 32'(mfb_tab[c]), 32'(mfb));
         rchk(`PLMCR_ADDR_ELAST, 32'(c), "elast reg");
      end
      // LED override with reserved bits written as ones
      cmd <= 8'h80;
      repeat (3) @(posedge sys_clk);
      chk("led", 32'h1, led);
      wr(`PLMCR_ADDR_LED, 16'hffff);
      rchk(`PLMCR_ADDR_LED, 32'h12, "led reg");
      wr(`PLMCR_ADDR_LED, 16'h0010);
      repeat (2) @(posedge sys_clk);
      chk("led", 32'h0, led);
      rchk(`PLMCR_ADDR_LED, 32'h10, "led reg");
      wr(`PLMCR_ADDR_LED, 16'h0002);
      repeat (2) @(posedge sys_clk);
      chk("led", 32'h1, led);
      // Crossover with auto-negotiation on
      cmd <= 8'h40;
      repeat (3) @(posedge sys_clk);
      chk("auto xo", 32'h1, xauto);
      chk("led", 32'h0, led);
      wr(`PLMCR_ADDR_PHY, 16'h4000);
      repeat (2) @(posedge sys_clk);
      chk("crossed", 32'h1, xpair);
      chk("auto xo", 32'h0, xauto);
      rchk(`PLMCR_ADDR_PHY, 32'h4000, "phy reg");
      wr(`PLMCR_ADDR_PHY, 16'h8000);
      repeat (2) @(posedge sys_clk);
      chk("crossed", 32'h0, xpair);
      chk("auto xo", 32'h1, xauto);
      // Automatic decision crosses the pairs once detected
      cmd <= 8'h60;
      repeat (3) @(posedge sys_clk);
      chk("crossed", 32'h1, xpair);
      cmd <= 8'h00;
      wr(`PLMCR_ADDR_PHY, 16'h0000);
      repeat (2) @(posedge sys_clk);
      chk("auto xo", 32'h0, xauto);
      n_inj = 0;
      wr(`PLMCR_ADDR_PHY, 16'h3800);
      repeat (4) @(posedge sys_clk);
      chk("inject pulses", 32'h1, n_inj);
      rchk(`PLMCR_ADDR_PHY, 32'h0, "phy reg");
      // Pause resolution over all duplex and ability combinations
      for (int k = 0; k < 32; k++) begin
         etx = k[4] & k[0] & (k[2] | (k[3] & k[1]));
         erx = k[4] & k[2] & (k[0] | (k[3] & k[1]));
         cmd <= 8'(k);
         repeat (3) @(posedge sys_clk);
         chk("pause rx", 32'(erx), prx);
         chk("pause tx", 32'(etx), ptx);
         if (k[4] && k[3] && k[1]) rchk(`PLMCR_ADDR_PHY, {18'h0, erx, etx, 12'h000}, "phy reg");
      end
      // Unmapped place answers with an error and changes nothing
      wr(8'h00, 16'hffff);
      chk("bresp", `PLMCR_RESP_DECERR, resp);
      rd_reg(8'h00);
      chk("rresp", `PLMCR_RESP_DECERR, resp);
      chk("rdata", 32'h0, rd);
      rchk(`PLMCR_ADDR_LED, 32'h2, "led reg");
      // Second reset with the strap low, then overwrite
      strap <= 1'b0;
      cmd <= 8'h00;
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rchk(`PLMCR_ADDR_PHY, 32'h0, "phy reg");
      wr(`PLMCR_ADDR_PHY, 16'h8000);
      rchk(`PLMCR_ADDR_PHY, 32'h8000, "phy reg");
      close_out;
   end

endmodule : plmcr_regs_bench
